// File: rtl/abs_pkg.sv
/*
 package for the bytewide static memory host port: widths, pin timing and
 state encoding. assumes one 250 MHz clock in the design that imports it.
*/
package abs_pkg;
    localparam int ABS_ADDR_W = 11;
    localparam int ABS_DATA_W = 8;
    localparam int ABS_DEPTH = 2048;
    localparam int ABS_CLK_PERIOD_PS = 4000;
    // pin timing figures in ns
    localparam int ABS_ACCESS_TIME_NS = 200;
    localparam int ABS_OE_ACCESS_NS = 100;
    localparam int ABS_WRITE_PULSE_NS = 75;
    localparam int ABS_WRITE_DATA_LEAD_TIME_NS = 40;
    localparam int ABS_STROBE_RECOVERY_TIME_NS = 10;
    localparam int ABS_WRITE_FLOAT_DELAY_NS = 35;
    localparam int ABS_DESELECT_FLOAT_DELAY_NS = 35;
    localparam int ABS_CYCLE_TIME_NS = 200;
    // least times round up to whole cycles
    function automatic int abs_cyc_up(input int ns);
        int c;
        c = (ns * 1000 + ABS_CLK_PERIOD_PS - 1) / ABS_CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int ABS_READ_CYC = abs_cyc_up(ABS_ACCESS_TIME_NS);
    localparam int ABS_WPULSE_CYC = abs_cyc_up(ABS_WRITE_PULSE_NS);
    localparam int ABS_LEAD_CYC = abs_cyc_up(ABS_WRITE_DATA_LEAD_TIME_NS);
    localparam int ABS_RECOV_CYC = abs_cyc_up(ABS_STROBE_RECOVERY_TIME_NS);
    localparam int ABS_FLOAT_CYC = abs_cyc_up(ABS_DESELECT_FLOAT_DELAY_NS);
    localparam int ABS_CNT_W = 8;
    typedef enum logic [2:0] {
        ABS_IDLE  = 3'b000,
        ABS_RSET  = 3'b001,
        ABS_READ  = 3'b010,
        ABS_WSET  = 3'b011,
        ABS_WRITE = 3'b100,
        ABS_RECOV = 3'b101
    } abs_state_t;
endpackage

// File: rtl/abs_host.sv
/*
 host controller that drives a bytewide asynchronous static memory through
 its address, data and three active-low strobes. every access is one byte:
 a request taken while idle runs a fixed sequence of phases and gives a
 one-cycle done pulse as the strobe phase ends, ahead of recovery, the read
 byte standing in o_rdata until the next read.
 strobe timing is counted in clock cycles from the package figures, so a
 slower clock only makes the pulses longer.
 assumes the memory pins are wired to the outputs here; the data wire level
 is resolved outside from the output enable (low = host drives) and comes
 back on i_data_bus. the supply-good level comes from a monitor outside and
 is synchronised here. one clock, no software registers.
*/
`timescale 1ns/1ps
// Contract
// - host holds address stable throughout a write
// - host keeps write strobe high for recovery before next cycle
// - host keeps output drive high during writes
// - select and strobe overlap at least 75 ns
// - write data valid 40 ns before earlier rising edge
module abs_host
    import abs_pkg::*;
#(
    parameter int READ_CYC   = ABS_READ_CYC,
    parameter int WPULSE_CYC = ABS_WPULSE_CYC,
    parameter int RECOV_CYC  = ABS_RECOV_CYC
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_reset,
    input  wire logic                  i_req,
    input  wire logic                  i_write,
    input  wire logic [ABS_ADDR_W-1:0] i_addr,
    input  wire logic [ABS_DATA_W-1:0] i_wdata,
    input  wire logic                  i_power_ok,
    input  wire logic [ABS_DATA_W-1:0] i_data_bus,
    output logic                       o_busy,
    output logic                       o_done,
    output logic [ABS_DATA_W-1:0]      o_rdata,
    output logic [ABS_ADDR_W-1:0]      o_byte_address,
    output logic [ABS_DATA_W-1:0]      o_data_bus,
    output logic                       o_data_bus_oe_n,
    output logic                       o_chip_select_n,
    output logic                       o_write_strobe_n,
    output logic                       o_output_drive_n
);
    abs_state_t              state;
    abs_state_t              next_state;
    logic [ABS_CNT_W-1:0]    cnt;
    logic [ABS_CNT_W-1:0]    next_cnt;
    logic                    pwr_meta;
    logic                    pwr_ok;
    logic [ABS_DATA_W-1:0]   dq_meta;
    logic [ABS_DATA_W-1:0]   dq_sync;

    // named decode of the current phase
    wire cnt_zero  = (cnt == '0);
    wire start     = i_req && pwr_ok && (state == ABS_IDLE);
    wire in_read   = (state == ABS_READ);
    wire in_write  = (state == ABS_WRITE);

    // pin levels for the coming cycle, decoded once; the output registers only
    // copy them, so every pin leaves a flop and no decode sits behind a pad
    wire next_sel_n = !((next_state == ABS_READ) || (next_state == ABS_WRITE));
    wire next_we_n  = (next_state != ABS_WRITE);
    wire next_od_n  = (next_state != ABS_READ); // never low in a write
    wire next_oe_n  = !((next_state == ABS_WSET) || (next_state == ABS_WRITE));
    wire phase_end  = (in_read || in_write) && cnt_zero; // last cycle of a strobe pulse
    wire capture    = in_read && cnt_zero;

    // power lockout: a low supply only stops new takes; an access already
    // running is finished, so the strobes never stop half way through a write
    // supply-good level passes two flops; the first feeds only the second
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pwr_meta <= 1'b0;
            pwr_ok   <= 1'b0;
        end else begin
            pwr_meta <= i_power_ok;
            pwr_ok   <= pwr_meta;
        end
    end

    // returned data wire, same two-flop path; only read once it has settled
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            dq_meta <= '0;
            dq_sync <= '0;
        end else begin
            dq_meta <= i_data_bus;
            dq_sync <= dq_meta;
        end
    end

    // phase lengths load the down-counter; the cast cuts the int on purpose
    function automatic logic [ABS_CNT_W-1:0] abs_phase_len(input int cycles);
        return ABS_CNT_W'(cycles);
    endfunction

    // phase budget at the default 4 ns clock:
    //   read  : one cycle of address setup with select high, then select and
    //           output drive low for READ_CYC + 3 cycles; the extra cycles pay
    //           for the two-flop data synchroniser plus one of margin
    //   write : one cycle with address and data out and strobes high, then
    //           select and write strobe low together for WPULSE_CYC cycles,
    //           so the data has led the rising edge by a full pulse
    //   recov : after a read the bus is left alone for the deselect float
    //           time; after a write the strobe stays high for the recovery
    //           time before the next take
    // trade-off: one fixed timing sized for the slowest grade; a faster part
    // only loses speed, never data
    // sequencer; each phase length counted down to zero
    always_comb begin
        next_state = state;
        next_cnt   = cnt_zero ? cnt : cnt - 1'b1;
        case (state)
            ABS_IDLE: begin
                if (start) begin
                    next_state = i_write ? ABS_WSET : ABS_RSET;
                    next_cnt   = '0;
                end
            end
            ABS_RSET: begin // address settles before select falls
                next_state = ABS_READ;
                next_cnt   = abs_phase_len(READ_CYC + 2); // room for the sync delay
            end
            ABS_READ: begin
                if (cnt_zero) begin
                    next_state = ABS_RECOV;
                    next_cnt   = abs_phase_len(ABS_FLOAT_CYC); // bus floats after deselect
                end
            end
            ABS_WSET: begin // address and data out, strobe still high
                next_state = ABS_WRITE;
                next_cnt   = abs_phase_len(WPULSE_CYC - 1); // overlap width
            end
            ABS_WRITE: begin
                if (cnt_zero) begin
                    next_state = ABS_RECOV;
                    next_cnt   = abs_phase_len(RECOV_CYC); // strobe high recovery
                end
            end
            ABS_RECOV: begin
                if (cnt_zero) begin
                    next_state = ABS_IDLE;
                end
            end
            default: begin
                next_state = ABS_IDLE;
                next_cnt   = '0;
            end
        endcase
    end

    // state and counter
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state <= ABS_IDLE;
            cnt   <= '0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // address and write data latched at the request, held until idle
    // the address stays put through recovery as well, so its hold time is met
    // without any counting of its own; the data drive is released as the strobes rise
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_byte_address <= '0;
            o_data_bus     <= '0;
        end else if (start) begin
            o_byte_address <= i_addr;
            o_data_bus     <= i_wdata;
        end
    end

    // strobes: select and write strobe fall together after setup, rise together
    // equal edges keep both edge orders of a write cycle in step
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_chip_select_n  <= 1'b1;
            o_write_strobe_n <= 1'b1;
            o_output_drive_n <= 1'b1;
            o_data_bus_oe_n  <= 1'b1;
        end else begin
            o_chip_select_n  <= next_sel_n;
            o_write_strobe_n <= next_we_n;
            o_output_drive_n <= next_od_n;
            // host drives only in write phases, float held through recovery
            o_data_bus_oe_n  <= next_oe_n;
        end
    end

    // read capture at end of read phase; done pulses once per access
    // the capture uses the synchronised wire, never the raw pin
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rdata <= '0;
            o_done  <= 1'b0;
            o_busy  <= 1'b0;
        end else begin
            o_done <= phase_end;
            o_busy <= (next_state != ABS_IDLE);
            if (capture) begin
                o_rdata <= dq_sync;
            end
        end
    end
endmodule

// File: tb/abs_host_checker.sv
/*
 pin checker for abs_host.
 assumes the default access timing at a 4 ns clock.
*/
`timescale 1ns/1ps
module abs_host_checker
    import abs_pkg::*;
#(
    parameter int READ_CYC   = ABS_READ_CYC,
    parameter int WPULSE_CYC = ABS_WPULSE_CYC,
    parameter int RECOV_CYC  = ABS_RECOV_CYC
) (
    input wire logic                  i_clk,
    input wire logic                  i_reset,
    input wire logic                  i_power_ok,
    input wire logic                  o_busy,
    input wire logic                  o_done,
    input wire logic [ABS_ADDR_W-1:0] o_byte_address,
    input wire logic [ABS_DATA_W-1:0] o_data_bus,
    input wire logic                  o_data_bus_oe_n,
    input wire logic                  o_chip_select_n,
    input wire logic                  o_write_strobe_n,
    input wire logic                  o_output_drive_n
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    logic [7:0] ovl;
    // width of the select and strobe overlap
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) ovl <= 8'h00;
        else ovl <= (!o_chip_select_n && !o_write_strobe_n) ? ovl + 8'h01 : 8'h00;
    end
    chk_pulse_wide: assert property ($rose(o_write_strobe_n) |-> ovl >= WPULSE_CYC)
        else $error("write pulse short");
    chk_data_lead: assert property ($rose(o_write_strobe_n) |-> $past(!o_data_bus_oe_n, 10)
        && $past(o_data_bus, 10) == o_data_bus)
        else $error("write data late");
    chk_addr_steady: assert property (!o_write_strobe_n |=> $stable(o_byte_address))
        else $error("address moved in write");
    chk_recover_gap: assert property ($rose(o_write_strobe_n) |-> o_write_strobe_n [*3])
        else $error("recovery short");
    chk_no_drive: assert property (!o_write_strobe_n |-> o_output_drive_n)
        else $error("output drive in write");
    chk_edges_paired: assert property ($fell(o_write_strobe_n) |-> $fell(o_chip_select_n))
        else $error("write start not paired");
    chk_read_setup: assert property ($fell(o_output_drive_n)
        |-> !o_chip_select_n && o_write_strobe_n && o_data_bus_oe_n)
        else $error("bad read strobes");
    chk_read_done: assert property ($fell(o_output_drive_n) |-> ##[50:56] o_done)
        else $error("read done off time");
    chk_power_block: assert property ((!i_power_ok [*5] ##0 !o_busy) |=> !o_busy)
        else $error("access in low power");
    cover property ($rose(o_write_strobe_n));
    cover property (!o_output_drive_n ##1 o_done);
    cover property (!i_power_ok [*5] ##0 !o_busy);
endmodule
bind abs_host abs_host_checker #(.READ_CYC(READ_CYC), .WPULSE_CYC(WPULSE_CYC), .RECOV_CYC(RECOV_CYC)) u_chk (
    .i_clk, .i_reset, .i_power_ok, .o_busy, .o_done, .o_byte_address, .o_data_bus,
    .o_data_bus_oe_n, .o_chip_select_n, .o_write_strobe_n, .o_output_drive_n);

// File: tb/abs_sram_model.sv
/*
 behavioural bytewide memory on the host pins.
 assumes pins wired straight from abs_host; returns the resolved wire.
*/
`timescale 1ns/1ps
module abs_sram_model
    import abs_pkg::*;
(
    input  wire logic                  i_power_ok,
    input  wire logic [ABS_ADDR_W-1:0] i_byte_address,
    input  wire logic [ABS_DATA_W-1:0] i_host_data,
    input  wire logic                  i_host_oe_n,
    input  wire logic                  i_chip_select_n,
    input  wire logic                  i_write_strobe_n,
    input  wire logic                  i_output_drive_n,
    output wire logic [ABS_DATA_W-1:0] o_data_bus
);
    logic [ABS_DATA_W-1:0] mem [ABS_DEPTH];
    logic [ABS_DATA_W-1:0] wlatch;
    logic [ABS_DATA_W-1:0] last = 8'h00;
    logic                  armed = 1'b0;
    wire                   wr_n = i_chip_select_n | i_write_strobe_n;
    // drive only in a clean read with good supply
    // any write strobe or deselect releases it at once
    wire drv = !i_chip_select_n && !i_output_drive_n && i_write_strobe_n && i_power_ok;
    // released wire shows the inverse of the last level, not a lucky hold
    assign o_data_bus = !i_host_oe_n ? i_host_data : drv ? mem[i_byte_address] : ~last;
    always @(o_data_bus) if (!i_host_oe_n || drv) last = o_data_bus;
    // later fall opens, earliest rise commits the latched byte
    always @(negedge wr_n) armed = i_power_ok;
    // latch only while the host drives, so a release in the same step as the
    // rising strobe cannot put the floating level into the committed byte
    always @* if (!wr_n && !i_host_oe_n) wlatch = o_data_bus;
    always @(posedge wr_n) begin
        if (armed && i_power_ok) mem[i_byte_address] = wlatch;
        armed = 1'b0;
    end
endmodule

// File: tb/tb_async_byte_sram_port.sv
/*
 self-checking bench for abs_host against a behavioural memory.
 assumes default timing parameters and a 250 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %0t got %h want %h", $time, g, e); end end
module tb_async_byte_sram_port
    import abs_pkg::*;
;
    logic                  i_clk = 0, i_reset = 1, i_req = 0, i_write = 0, i_power_ok = 1;
    logic                  o_busy, o_done, hoe_n, cs_n, we_n, od_n;
    logic [ABS_ADDR_W-1:0] i_addr = '0, addr;
    logic [ABS_DATA_W-1:0] i_wdata = '0, o_rdata, hdata;
    wire  [ABS_DATA_W-1:0] bus;
    logic [ABS_DATA_W-1:0] shadow [ABS_DEPTH];
    logic [ABS_ADDR_W-1:0] used [$];
    logic [15:0]           lfsr = 16'hA1D6;
    int                    bad_count = 0, samples_checked = 0;
    abs_host dut (.i_clk, .i_reset, .i_req, .i_write, .i_addr, .i_wdata, .i_power_ok, .i_data_bus(bus),
        .o_busy, .o_done, .o_rdata, .o_byte_address(addr), .o_data_bus(hdata), .o_data_bus_oe_n(hoe_n),
        .o_chip_select_n(cs_n), .o_write_strobe_n(we_n), .o_output_drive_n(od_n));
    abs_sram_model mem (.i_power_ok, .i_byte_address(addr), .i_host_data(hdata), .i_host_oe_n(hoe_n),
        .i_chip_select_n(cs_n), .i_write_strobe_n(we_n), .i_output_drive_n(od_n), .o_data_bus(bus));
    initial forever #2 i_clk = ~i_clk;
    function automatic logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // expected read byte: the last completed write to that location
    function automatic logic [ABS_DATA_W-1:0] expect_byte(input logic [ABS_ADDR_W-1:0] a);
        return shadow[a];
    endfunction
    // one request, held one edge, then wait for done and idle
    task automatic access(input logic w, input logic [10:0] a, input logic [7:0] d, input logic ok);
        @(posedge i_clk);
        i_req <= 1'b1;
        i_write <= w;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_req <= 1'b0;
        for (int n = 0; n < 200 && o_done !== 1'b1; n++) @(posedge i_clk);
        `CHK(o_done, ok)
        if (w && ok) shadow[a] = d;
        if (w && ok) used.push_back(a);
        if (!w && ok) `CHK(o_rdata, expect_byte(a))
        for (int n = 0; n < 200 && o_busy === 1'b1; n++) @(posedge i_clk);
    endtask
    task automatic give_verdict();
        $display("checked %0d bad %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (3) @(posedge i_clk);
        // edge addresses, one overwritten straight after
        access(1, 11'h000, 8'h5A, 1);
        access(1, 11'h7FF, 8'hA5, 1);
        access(1, 11'h7FF, 8'h3C, 1);
        for (int k = 0; k < 12; k++) begin
            lfsr = next_rand(lfsr);
            access(1, lfsr[10:0], lfsr[15:8], 1);
        end
        foreach (used[k]) access(0, used[k], 8'h00, 1);
        $display("write and read test ended");
        // supply low: request refused, contents kept
        i_power_ok <= 1'b0;
        repeat (6) @(posedge i_clk);
        access(1, 11'h000, 8'hFF, 0);
        i_power_ok <= 1'b1;
        repeat (6) @(posedge i_clk);
        access(0, 11'h000, 8'h00, 1);
        $display("power test ended");
        give_verdict();
    end
    initial begin
        #80000;
        bad_count++;
        give_verdict();
    end
endmodule
